// [dv/sspc_host.sv]
// sspc_host: host model that loads frames into the serial port.
// assumes: the bench calls send(); pins change just after rising clk.
`timescale 1ns/1ps
module sspc_host
(
	// clock
	input  logic clk,
	// serial pins
	output logic ser_sel_n,
	output logic ser_data,
	output logic ser_clk
);
	// idle: deselected, shift clock low
	initial
	begin
		ser_sel_n = 1'b1;
		ser_data  = 1'b0;
		ser_clk   = 1'b0;
	end

	// n bits msb first; bad lifts select while the clock is high
	task automatic send(input int n, input logic [31:0] w, input bit bad);
		int i;
		@(posedge clk);
		ser_sel_n <= 1'b0;
		for (i = n - 1; i >= 0; i--)
		begin
			@(posedge clk);
			ser_data <= w[i];
			@(posedge clk);
			ser_clk <= 1'b1;
			@(posedge clk);
			if (bad && i == 0)
				ser_sel_n <= 1'b1;
			@(posedge clk);
			ser_clk <= 1'b0;
		end
		@(posedge clk);
		ser_sel_n <= 1'b1;
		ser_data  <= ~ser_data; // released line, last value not kept
		repeat (2) @(posedge clk);
	endtask
endmodule

// [dv/tb.sv]
// tb: self-checking bench for the serial port controller.
// assumes: sspc_host drives the serial pins; clk runs at 40 MHz.
`timescale 1ns/1ps
module tb;
	typedef struct {int n; logic [31:0] w; int s; logic [23:0] e;} sspc_row_s;

	// driven inputs
	logic        clk, srst, cfg_mode, main_ref_div_out, sec_ref_div_out;
	logic        main_fb_pulse, sec_fb_pulse, divided_ref_out;
	logic        dual_p_i, dual_n_i, ser_sel_n, ser_data, ser_clk;
	// observed outputs
	logic        dual_p_o, dual_n_o, dual_p_oe, dual_n_oe, outa_o, outb_o;
	logic        outb_oe, lock_detect_out, lock_window_select, main_pol_neg;
	logic        sec_pol_neg, ext_ref_sel, sec_ref_half_step;
	logic [7:0]  control_byte;
	logic [23:0] main_loop_divider, sec_reference_config;
	logic [15:0] active_ref_divider, sec_loop_divider, converter_levels;
	int          failures, checks_done, i;
	// frames in order, with the register image each should leave
	sspc_row_s   rows [15] = '{
		'{8, 32'h000000a5, 0, 24'h0000a5}, '{16, 32'h00001234, 2, 24'h0},
		'{32, 32'h4000beef, 3, 24'h0}, '{32, 32'h20c00001, 1, 24'hc00001},
		'{0, 32'h0, 2, 24'h001234}, '{0, 32'h0, 3, 24'h00beef},
		'{32, 32'h3000cafe, 4, 24'h00cafe}, '{32, 32'h60001111, 4, 24'h00cafe},
		'{12, 32'h00000fff, 0, 24'h0000a5}, '{16, 32'h0000dead, 4, 24'h00cafe},
		'{24, 32'h00000123, 2, 24'h00dead}, '{32, 32'h50300000, 5, 24'h300000},
		'{32, 32'h0000003c, 0, 24'h00003c}, '{32, 32'h10005678, 2, 24'h00dead},
		'{32, 32'h20000001, 2, 24'h005678}};

	sspc_top dut (.clk, .srst, .ser_sel_n, .ser_data, .ser_clk, .cfg_mode,
		.main_ref_div_out, .sec_ref_div_out, .main_fb_pulse, .sec_fb_pulse,
		.divided_ref_out, .dual_p_i, .dual_n_i, .dual_p_o, .dual_n_o,
		.dual_p_oe, .dual_n_oe, .outa_o, .outb_o, .outb_oe, .lock_detect_out,
		.control_byte, .main_loop_divider, .active_ref_divider,
		.sec_loop_divider, .converter_levels, .sec_reference_config,
		.lock_window_select, .main_pol_neg, .sec_pol_neg, .ext_ref_sel,
		.sec_ref_half_step);
	sspc_host host (.clk, .ser_sel_n, .ser_data, .ser_clk);

	// clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// compare and count
	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
		input string what);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask

	// one frame, then wait until the register update has landed
	task automatic frame(input int n, input logic [31:0] w, input bit bad);
		if (n > 0)
			host.send(n, w, bad);
		repeat (2) @(posedge clk);
		#1;
	endtask

	// reference pulses on both loops, feedback pulses as enabled
	task automatic pulse(input int n, input logic mfb, input logic sfb);
		repeat (n)
		begin
			@(posedge clk);
			{main_ref_div_out, sec_ref_div_out} <= 2'b11;
			{main_fb_pulse, sec_fb_pulse} <= {mfb, sfb};
			@(posedge clk);
			{main_ref_div_out, sec_ref_div_out} <= 2'b00;
			{main_fb_pulse, sec_fb_pulse} <= 2'b00;
			repeat (20) @(posedge clk);
		end
		#1;
	endtask

	// register image picked by a row
	function automatic logic [23:0] obs(input int s);
		case (s)
			0: obs = {16'h0, control_byte};
			1: obs = main_loop_divider;
			2: obs = {8'h0, active_ref_divider};
			3: obs = {8'h0, sec_loop_divider};
			4: obs = {8'h0, converter_levels};
			default: obs = sec_reference_config;
		endcase
	endfunction

	// verdict and end of run
	task automatic wrap_up;
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog
	initial
	begin
		repeat (30000) @(posedge clk);
		failures++;
		wrap_up;
	end

	// main sequence
	initial
	begin
		failures = 0;
		checks_done = 0;
		{srst, cfg_mode, main_ref_div_out, sec_ref_div_out} = 4'h8;
		{main_fb_pulse, sec_fb_pulse, divided_ref_out} = 3'h0;
		{dual_p_i, dual_n_i} = 2'h0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 15; i++)
		begin
			frame(rows[i].n, rows[i].w, 1'b0);
			chk(obs(rows[i].s), rows[i].e, "row");
		end
		chk(lock_window_select, 1'b0, "window select");
		// select lifted under a high clock drops the frame, then resyncs
		frame(8, 32'hff, 1'b1);
		chk(control_byte, 8'h3c, "bad frame kept");
		frame(8, 32'h00, 1'b0);
		chk(control_byte, 8'h00, "after resync");
		// lock detect over both loops and standby
		pulse(4, 1'b1, 1'b1);
		chk(lock_detect_out, 1'b1, "both locked");
		pulse(4, 1'b1, 1'b0);
		chk(lock_detect_out, 1'b0, "secondary unlocked");
		frame(8, 32'h04, 1'b0);
		pulse(4, 1'b1, 1'b0);
		chk(lock_detect_out, 1'b1, "secondary standby");
		frame(8, 32'h06, 1'b0);
		pulse(2, 1'b1, 1'b1);
		chk(lock_detect_out, 1'b0, "both standby");
		// output a: static level, then each divider pulse
		frame(8, 32'h80, 1'b0);
		frame(32, 32'h50000000, 1'b0);
		chk(outa_o, 1'b1, "static level");
		for (i = 1; i < 3; i++)
		begin
			frame(32, 32'h50000000 | (i << 20), 1'b0);
			chk(outa_o, 1'b0, "rests low");
			@(posedge clk);
			{sec_ref_div_out, main_ref_div_out} <= i[1:0];
			@(posedge clk);
			{sec_ref_div_out, main_ref_div_out} <= 2'b00;
			#1;
			chk(outa_o, 1'b1, "pulse high");
			@(posedge clk);
			#1;
			chk(outa_o, 1'b0, "back low");
		end
		frame(32, 32'h50300000, 1'b0);
		chk(outa_o, 1'b0, "pulse flag rests low");
		// a lone reference pulse opens the main window, flag goes high
		@(posedge clk);
		main_ref_div_out <= 1'b1;
		@(posedge clk);
		main_ref_div_out <= 1'b0;
		@(posedge clk);
		#1;
		chk(outa_o, 1'b1, "pulse flag high");
		// dual pins and mode pin
		divided_ref_out <= 1'b1;
		dual_n_i <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({dual_p_o, dual_n_o, dual_p_oe, dual_n_oe}, 4'hb, "outputs");
		chk({main_pol_neg, sec_pol_neg, sec_ref_half_step}, 3'h0, "pos");
		cfg_mode <= 1'b1;
		frame(8, 32'h40, 1'b0);
		chk({dual_p_oe, dual_n_oe, main_pol_neg, sec_pol_neg}, 4'h2, "pol");
		chk({sec_ref_half_step, ext_ref_sel, outb_oe}, 3'h6, "mode hi");
		cfg_mode <= 1'b0;
		frame(0, 32'h0, 1'b0);
		chk({outb_o, outb_oe, ext_ref_sel}, 3'h6, "output b");
		frame(8, 32'h42, 1'b0);
		chk(outb_oe, 1'b0, "standby floats b");
		// reset in mid-run
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(control_byte, 8'h02, "reset control");
		chk(main_loop_divider, 24'h0, "reset main");
		chk({lock_detect_out, outb_oe}, 2'b00, "reset ld");
		wrap_up;
	end
endmodule

// [verilog/sspc_frame_if.sv]
// sspc_frame_if: finished frame from the serial receiver to the core.
// assumes: one clock; done is a one-cycle pulse, len and word stand with it.
`timescale 1ns/1ps
interface sspc_frame_if;
	logic        done;
	logic [5:0]  len;
	logic [31:0] word;

	modport rx   (output done, output len, output word);
	modport core (input done, input len, input word);
endinterface

// [verilog/sspc_map.svh]
// sspc_map.svh: register addresses, frame lengths, field positions,
// reset values and lock window counts of the serial port controller.
// assumes: included by its bare name from the design modules.
`ifndef SSPC_MAP_SVH
`define SSPC_MAP_SVH

// address nibble of a 32-clock frame
`define SSPC_ADDR_CTRL      4'h0
`define SSPC_ADDR_HOLD      4'h1
`define SSPC_ADDR_MAIN      4'h2
`define SSPC_ADDR_CONV      4'h3
`define SSPC_ADDR_SEC_HOLD  4'h4
`define SSPC_ADDR_SEC_CFG   4'h5

// frame lengths in shift clocks
`define SSPC_LEN_CTRL       6'h08
`define SSPC_LEN_HOLD       6'h10
`define SSPC_LEN_MAIN       6'h18
`define SSPC_LEN_ADDR       6'h20

// field positions
`define SSPC_C_OUTA_LEVEL   7
`define SSPC_C_OUTB_LEVEL   6
`define SSPC_C_SEC_STBY     2
`define SSPC_C_MAIN_STBY    1
`define SSPC_N_LOCK_WIN     22
`define SSPC_SC_OUTA_HI     21
`define SSPC_SC_OUTA_LO     20

// reset values: main loop starts in standby, output b floats
`define SSPC_CTRL_RST       8'h02
`define SSPC_ZERO16         16'h0000
`define SSPC_ZERO24         24'h000000

// lock window widths in clk cycles
`define SSPC_WIN_NARROW     8'h04
`define SSPC_WIN_WIDE       8'h10
`define SSPC_WIN_SEC        8'h08

`endif

// [verilog/sspc_pkg.sv]
// sspc_pkg: types shared by the serial port controller modules.
// assumes: compiled before every other design file.
package sspc_pkg;

	// destination of a finished frame
	typedef enum logic [2:0] {
		SSPC_DEST_NONE,
		SSPC_DEST_CTRL,
		SSPC_DEST_HOLD,
		SSPC_DEST_MAIN,
		SSPC_DEST_CONV,
		SSPC_DEST_SEC_HOLD,
		SSPC_DEST_SEC_CFG
	} sspc_dest_e;

	// serial receiver states
	typedef enum logic [1:0] {
		SSPC_RX_IDLE,
		SSPC_RX_SHIFT,
		SSPC_RX_LOST
	} sspc_rx_e;

endpackage

// [verilog/sspc_rx.sv]
// sspc_rx: serial receiver, samples select, data and shift clock on clk.
// assumes: serial pins are synchronous to clk and slower than clk / 2.
`timescale 1ns/1ps
`include "sspc_map.svh"
module sspc_rx
	import sspc_pkg::*;
(
	// clock and reset
	input  logic clk,
	input  logic srst,
	// serial pins
	input  logic ser_sel_n,
	input  logic ser_data,
	input  logic ser_clk,
	// finished frame
	sspc_frame_if.rx frm
);

	sspc_rx_e    state_q;
	logic        sclk_q;
	logic        sel_n_q;
	logic [5:0]  cnt_q;
	logic [31:0] sh_q;
	logic        done_q;
	logic [5:0]  len_q;
	logic [31:0] word_q;

	// edge and level decode of the sampled pins
	wire rise    = ser_clk & ~sclk_q;
	wire sel_low = ~ser_sel_n & sel_n_q;
	wire sel_up  = ser_sel_n & ~sel_n_q;
	wire resync  = ser_sel_n & ~ser_clk;
	wire cnt_max = &cnt_q;

	// pin history
	always_ff @(posedge clk)
	begin
		sclk_q  <= srst ? 1'h0 : ser_clk;
		sel_n_q <= srst ? 1'h1 : ser_sel_n;
	end

	// frame state: select toggled under a high clock loses sync
	always_ff @(posedge clk)
	begin
		if (srst)
			state_q <= SSPC_RX_IDLE;
		else
			unique case (state_q)
				SSPC_RX_IDLE:
					if (sel_low)
						state_q <= ser_clk ? SSPC_RX_LOST : SSPC_RX_SHIFT; // see R9
				SSPC_RX_SHIFT:
					if (sel_up)
						state_q <= ser_clk ? SSPC_RX_LOST : SSPC_RX_IDLE; // see R9
				SSPC_RX_LOST:
					if (resync)
						state_q <= SSPC_RX_IDLE; // see R10
			endcase
	end

	// shift register, msb first on rising shift clock while selected
	always_ff @(posedge clk)
	begin
		if (srst || resync || state_q != SSPC_RX_SHIFT)
		begin
			cnt_q <= 6'h00; // see R10
			sh_q  <= 32'h0;
		end
		else if (rise)
		begin
			cnt_q <= cnt_max ? cnt_q : cnt_q + 6'h01;
			sh_q  <= {sh_q[30:0], ser_data}; // see R3 R1
		end
	end

	// hand the frame over when select returns high
	wire frame_end = (state_q == SSPC_RX_SHIFT) & sel_up & ~ser_clk;
	always_ff @(posedge clk)
	begin
		done_q <= ~srst & frame_end; // see R2
		if (frame_end)
		begin
			len_q  <= cnt_q;
			word_q <= sh_q;
		end
	end

	assign frm.done = done_q;
	assign frm.len  = len_q;
	assign frm.word = word_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence shift_bit;
		state_q == SSPC_RX_SHIFT && rise && !resync;
	endsequence
	sequence closing;
		state_q == SSPC_RX_SHIFT && sel_up && !ser_clk;
	endsequence

	msb_first_a: assert property (shift_bit |=> // see R3
		sh_q == {$past(sh_q[30:0]), $past(ser_data)})
		else $error("shift register did not take data msb first");
	frame_end_a: assert property (closing |=> // see R2
		done_q && len_q == $past(cnt_q) && word_q == $past(sh_q))
		else $error("frame not handed over at select release");
	resync_clear_a: assert property (resync |=> // see R10
		cnt_q == 6'h00 && state_q != SSPC_RX_LOST)
		else $error("receiver did not resynchronise");
	lost_hold_a: assert property (state_q == SSPC_RX_SHIFT && sel_up // see R9
		&& ser_clk |=> state_q == SSPC_RX_LOST && !done_q)
		else $error("select change under high clock not discarded");

endmodule

// [verilog/sspc_top.sv]
// sspc_top: serial loading port of a dual loop synthesiser with its
// register file, double buffered dividers, lock detect and pin logic.
// assumes: all inputs synchronous to clk; divider and detector pulses
// are one clk cycle wide and come from counters outside this block.
`timescale 1ns/1ps
`include "sspc_map.svh"

// Behaviour
// R1: host holds select low while all bits of a frame are clocked.
// R2: select returning high moves the shifted word to its register.
// R3: data goes msb first, sampled on rising shift clock.
// R4: 8 clocks load control, 16 reference holding, 24 main divider.
// R5: 32 clocks pick the register by address nibble 0 to 5.
// R6: converter, secondary holding and secondary config need 32 clocks.
// R7: main divider write copies reference holding into active divider.
// R8: main divider write also copies secondary holding into secondary.
// R9: host never toggles select while shift clock is high.
// R10: select high with clock low resynchronises the receiver.
// R11: lock detect is the AND of both loop lock indications.
// R12: main lock window chosen by a main divider bit, secondary fixed.
// R13: standby loop ignored; both in standby holds lock detect low.
// R14: loop lock high when detector inputs agree within the window.
// R15: after power-up lock detect shows not locked until lock.
// R16: output a picks static level, either divider, or detector pulse.
// R17: divider and pulse selections rest low and pulse high.
// R18: mode low drives differential divided reference, positive polarity.
// R19: mode high makes dual pins polarity inputs, secondary then main.
// R20: secondary divider uses half steps with mode high.
// R21: mode low drives output b from a bit, else it picks reference.
// R22: main loop standby floats output b.
// R23: polarity input low is positive, high is negative.
// R24: address nibble leads the 32-bit frame, payload trails.
// R25: frames of any other length change no register.
module sspc_top
	import sspc_pkg::*;
#(
	parameter logic [7:0] WIN_NARROW = `SSPC_WIN_NARROW,
	parameter logic [7:0] WIN_WIDE   = `SSPC_WIN_WIDE,
	parameter logic [7:0] WIN_SEC    = `SSPC_WIN_SEC
)
(
	// clock and reset
	input  logic        clk,
	input  logic        srst,
	// serial port
	input  logic        ser_sel_n,
	input  logic        ser_data,
	input  logic        ser_clk,
	// configuration pin
	input  logic        cfg_mode,
	// counter pulses
	input  logic        main_ref_div_out,
	input  logic        sec_ref_div_out,
	input  logic        main_fb_pulse,
	input  logic        sec_fb_pulse,
	input  logic        divided_ref_out,
	// dual purpose pins
	input  logic        dual_p_i,
	input  logic        dual_n_i,
	output logic        dual_p_o,
	output logic        dual_n_o,
	output logic        dual_p_oe,
	output logic        dual_n_oe,
	// general outputs
	output logic        outa_o,
	output logic        outb_o,
	output logic        outb_oe,
	output logic        lock_detect_out,
	// settings to the analog and counter sections
	output logic [7:0]  control_byte,
	output logic [23:0] main_loop_divider,
	output logic [15:0] active_ref_divider,
	output logic [15:0] sec_loop_divider,
	output logic [15:0] converter_levels,
	output logic [23:0] sec_reference_config,
	output logic        lock_window_select,
	output logic        main_pol_neg,
	output logic        sec_pol_neg,
	output logic        ext_ref_sel,
	output logic        sec_ref_half_step
);

	sspc_frame_if frm ();

	sspc_rx u_rx (
		.clk       (clk),
		.srst      (srst),
		.ser_sel_n (ser_sel_n),
		.ser_data  (ser_data),
		.ser_clk   (ser_clk),
		.frm       (frm.rx)
	);

	// destination of a frame from its length and leading nibble
	function automatic sspc_dest_e dest_of(
		input logic [5:0] len,
		input logic [3:0] nib
	);
		sspc_dest_e d;
		d = SSPC_DEST_NONE;
		unique case (len)
			`SSPC_LEN_CTRL: d = SSPC_DEST_CTRL; // see R4
			`SSPC_LEN_HOLD: d = SSPC_DEST_HOLD; // see R4
			`SSPC_LEN_MAIN: d = SSPC_DEST_MAIN; // see R4
			`SSPC_LEN_ADDR:
				unique case (nib) // see R5 R24
					`SSPC_ADDR_CTRL:     d = SSPC_DEST_CTRL;
					`SSPC_ADDR_HOLD:     d = SSPC_DEST_HOLD;
					`SSPC_ADDR_MAIN:     d = SSPC_DEST_MAIN;
					`SSPC_ADDR_CONV:     d = SSPC_DEST_CONV;
					`SSPC_ADDR_SEC_HOLD: d = SSPC_DEST_SEC_HOLD;
					`SSPC_ADDR_SEC_CFG:  d = SSPC_DEST_SEC_CFG;
					default:             d = SSPC_DEST_NONE;
				endcase
			default: d = SSPC_DEST_NONE; // see R25
		endcase
		return d;
	endfunction

	logic [7:0]  control_byte_q;
	logic [15:0] ref_hold_q;
	logic [23:0] main_div_q;
	logic [15:0] conv_q;
	logic [15:0] sec_hold_q;
	logic [23:0] sec_cfg_q;
	logic [15:0] act_ref_q;
	logic [15:0] sec_div_q;

	// write strobes, payload sits in the trailing bits
	sspc_dest_e dest;
	assign dest = dest_of(frm.len, frm.word[31:28]);
	wire [31:0] pay     = frm.word;
	wire we_ctrl     = frm.done & (dest == SSPC_DEST_CTRL);
	wire we_hold     = frm.done & (dest == SSPC_DEST_HOLD);
	wire we_main     = frm.done & (dest == SSPC_DEST_MAIN);
	wire we_conv     = frm.done & (dest == SSPC_DEST_CONV); // see R6
	wire we_sec_hold = frm.done & (dest == SSPC_DEST_SEC_HOLD); // see R6
	wire we_sec_cfg  = frm.done & (dest == SSPC_DEST_SEC_CFG); // see R6

	// control byte and holding registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			control_byte_q <= `SSPC_CTRL_RST;
			ref_hold_q     <= `SSPC_ZERO16;
			sec_hold_q     <= `SSPC_ZERO16;
		end
		else
		begin
			if (we_ctrl)
				control_byte_q <= pay[7:0]; // see R2
			if (we_hold)
				ref_hold_q <= pay[15:0];
			if (we_sec_hold)
				sec_hold_q <= pay[15:0];
		end
	end

	// main divider with the simultaneous double buffer transfer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			main_div_q <= `SSPC_ZERO24;
			act_ref_q  <= `SSPC_ZERO16;
			sec_div_q  <= `SSPC_ZERO16;
		end
		else if (we_main)
		begin
			main_div_q <= pay[23:0];
			act_ref_q  <= ref_hold_q; // see R7
			sec_div_q  <= sec_hold_q; // see R8
		end
	end

	// registers reachable only by addressed frames
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			conv_q    <= `SSPC_ZERO16;
			sec_cfg_q <= `SSPC_ZERO24;
		end
		else
		begin
			if (we_conv)
				conv_q <= pay[15:0];
			if (we_sec_cfg)
				sec_cfg_q <= pay[23:0];
		end
	end

	// control fields
	wire main_stby = control_byte_q[`SSPC_C_MAIN_STBY];
	wire sec_stby  = control_byte_q[`SSPC_C_SEC_STBY];
	wire outb_bit  = control_byte_q[`SSPC_C_OUTB_LEVEL];
	wire [1:0] outa_sel = {sec_cfg_q[`SSPC_SC_OUTA_HI],
		sec_cfg_q[`SSPC_SC_OUTA_LO]};
	assign lock_window_select = main_div_q[`SSPC_N_LOCK_WIN]; // see R12

	// per loop inputs: index 0 main, 1 secondary
	wire [1:0] ref_p = {sec_ref_div_out, main_ref_div_out};
	wire [1:0] fb_p  = {sec_fb_pulse, main_fb_pulse};
	wire [1:0] stby  = {sec_stby, main_stby};
	wire [7:0] win [2];
	assign win[0] = lock_window_select ? WIN_WIDE : WIN_NARROW; // see R12
	assign win[1] = WIN_SEC; // see R12
	wire [1:0] loop_lock;
	wire [1:0] loop_open;

	// phase window lock detector, one per loop
	for (genvar i = 0; i < 2; i++)
	begin : g_lock
		logic       open_q;
		logic       ref_first_q;
		logic [7:0] gap_q;
		logic       lock_q;
		wire both  = ref_p[i] & fb_p[i];
		wire any   = ref_p[i] | fb_p[i];
		wire other = open_q & (ref_first_q ? fb_p[i] : ref_p[i]);
		wire late  = open_q & (gap_q >= win[i]);

		always_ff @(posedge clk)
		begin
			if (srst || stby[i])
			begin
				open_q      <= 1'h0;
				ref_first_q <= 1'h0;
				gap_q       <= 8'h00;
				lock_q      <= 1'h0; // see R15
			end
			else if (both)
			begin
				open_q <= 1'h0;
				lock_q <= ~open_q; // see R14
			end
			else if (other)
			begin
				open_q <= 1'h0;
				lock_q <= (gap_q < win[i]); // see R14
			end
			else if (any)
			begin
				open_q      <= 1'h1;
				ref_first_q <= ref_p[i];
				gap_q       <= 8'h00;
				if (open_q)
					lock_q <= 1'h0; // see R14
			end
			else if (open_q)
			begin
				gap_q <= (&gap_q) ? gap_q : gap_q + 8'h01;
				// a missing partner closes the window so the flag rests low
				if (late)
				begin
					open_q <= 1'h0; // see R17
					lock_q <= 1'h0; // see R14
				end
			end
		end

		assign loop_lock[i] = lock_q;
		assign loop_open[i] = open_q;
	end

	// combined lock detect, standby loops drop out of the product
	logic ld_q;
	wire ld_d = ((loop_lock[0] | main_stby) & (loop_lock[1] | sec_stby)) // see R11
		& ~(main_stby & sec_stby); // see R13
	always_ff @(posedge clk)
	begin
		ld_q <= srst ? 1'h0 : ld_d; // see R15
	end

	// output a selection, pulses rest low
	logic outa_q;
	wire pd_pulse = |loop_open; // see R17
	wire outa_d = (outa_sel == 2'h0) ? control_byte_q[`SSPC_C_OUTA_LEVEL] :
		(outa_sel == 2'h1) ? main_ref_div_out : // see R16
		(outa_sel == 2'h2) ? sec_ref_div_out : pd_pulse; // see R16 R17
	always_ff @(posedge clk)
	begin
		outa_q <= srst ? 1'h0 : outa_d;
	end

	// mode pin: polarity inputs or differential reference outputs
	logic main_pol_q;
	logic sec_pol_q;
	always_ff @(posedge clk)
	begin
		main_pol_q <= ~srst & cfg_mode & dual_n_i; // see R19 R23
		sec_pol_q  <= ~srst & cfg_mode & dual_p_i; // see R19 R23
	end

	// pin drive
	assign dual_p_o  = divided_ref_out; // see R18
	assign dual_n_o  = ~divided_ref_out; // see R18
	assign dual_p_oe = ~cfg_mode; // see R18 R19
	assign dual_n_oe = ~cfg_mode;
	assign outb_o    = outb_bit; // see R21
	assign outb_oe   = ~cfg_mode & ~main_stby; // see R21 R22
	assign ext_ref_sel       = cfg_mode & outb_bit; // see R21
	assign sec_ref_half_step = cfg_mode; // see R20
	assign main_pol_neg = main_pol_q;
	assign sec_pol_neg  = sec_pol_q;
	assign outa_o = outa_q;
	assign lock_detect_out = ld_q;

	// register images
	assign control_byte         = control_byte_q;
	assign main_loop_divider    = main_div_q;
	assign active_ref_divider   = act_ref_q;
	assign sec_loop_divider     = sec_div_q;
	assign converter_levels     = conv_q;
	assign sec_reference_config = sec_cfg_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence main_write;
		frm.done && dest == SSPC_DEST_MAIN;
	endsequence
	sequence both_idle;
		main_stby && sec_stby;
	endsequence

	ctrl_len_a: assert property (frm.done && frm.len == 6'h08 // see R4
		|=> control_byte_q == $past(frm.word[7:0]))
		else $error("8-clock frame did not load control byte");
	hold_len_a: assert property (frm.done && frm.len == 6'h10 // see R4
		|=> ref_hold_q == $past(frm.word[15:0]))
		else $error("16-clock frame did not load reference holding");
	conv_addr_a: assert property (frm.done && frm.len == 6'h20 // see R5
		&& frm.word[31:28] == 4'h3 |=> conv_q == $past(frm.word[15:0]))
		else $error("addressed frame missed converter register");
	addr_only_a: assert property (frm.done && frm.len != 6'h20 // see R6
		|=> $stable(conv_q) && $stable(sec_hold_q) && $stable(sec_cfg_q))
		else $error("addressed-only register hit by short frame");
	ref_copy_a: assert property (main_write // see R7
		|=> act_ref_q == $past(ref_hold_q)
		&& main_div_q == $past(frm.word[23:0]))
		else $error("reference holding not transferred");
	sec_copy_a: assert property (main_write // see R8
		|=> sec_div_q == $past(sec_hold_q))
		else $error("secondary holding not transferred");
	bad_len_a: assert property (frm.done && dest == SSPC_DEST_NONE // see R25
		|=> $stable(control_byte_q) && $stable(main_div_q)
		&& $stable(ref_hold_q))
		else $error("unknown frame altered a register");
	lock_and_a: assert property (lock_detect_out && !$past(main_stby) // see R11
		&& !$past(sec_stby) |-> $past(loop_lock) == 2'h3)
		else $error("lock detect high without both loops locked");
	both_stby_a: assert property (both_idle ##1 both_idle // see R13
		|-> !lock_detect_out)
		else $error("lock detect high with both loops in standby");
	boot_unlock_a: assert property ($fell(srst) |-> !lock_detect_out // see R15
		##1 (lock_detect_out == $past(ld_d)))
		else $error("lock detect not low after reset");
	outa_ref_a: assert property (outa_sel == 2'h1 // see R16
		|=> outa_o == $past(main_ref_div_out))
		else $error("output a not following main reference");
	outb_float_a: assert property (main_stby |-> !outb_oe) // see R22
		else $error("output b driven with main loop in standby");
	pin_dir_a: assert property (cfg_mode |-> !dual_p_oe && !dual_n_oe // see R19
		##1 (main_pol_neg == $past(dual_n_i)))
		else $error("dual pins not inputs with mode high");

endmodule
